// ==== drive_run_supervisor_params.svh ====
// constants of the drive run supervisor: offsets, fields, resets, timing
`ifndef DRIVE_RUN_SUPERVISOR_PARAMS_SVH
`define DRIVE_RUN_SUPERVISOR_PARAMS_SVH
`define OFF_CTRL 8'h00
`define OFF_TOTAL_LIMIT 8'h04
`define OFF_FREQ 8'h08
`define OFF_DELAY 8'h0c
`define OFF_TIMER_SET 8'h10
`define OFF_PRES_LIMIT 8'h14
`define OFF_STATUS 8'h18
`define OFF_REMAIN 8'h1c
`define OFF_HOURS 8'h20
`define OFF_IRQ_STAT 8'h24
`define OFF_IRQ_MASK 8'h28
`define CTRL_ACTION 0
`define CTRL_FAN 1
`define CTRL_TIMER_EN 2
`define CTRL_SRC_LO 3
`define CTRL_SRC_HI 4
`define CTRL_PROT 5
`define IRQ_TIMER 0
`define IRQ_PRES 1
`define IRQ_TOTAL 2
`define IRQ_DORMANT 3
`define IRQ_WAKE 4
`define IRQ_BITS 5
`define RESET_ZERO 32'h0000_0000
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define CLK_PERIOD_NS 4
`define TICK_TIME_NS 100000000
`define TICK_CYCLES (`TICK_TIME_NS / `CLK_PERIOD_NS)
`define DSEC_PER_DMIN 60
`define DSEC_PER_HOUR 36000
`define FAN_TEMP_C 40
`define AI_FULL 1024
`define AI_SHIFT 10
`endif

// ==== drive_run_supervisor_pkg.sv ====
// types of the drive run supervisor
package drive_run_supervisor_pkg;
	typedef enum logic [1:0] {IDLE_ST, RUN_ST, DORM_ST, HALT_ST} run_e;
	typedef struct packed {
		logic action;
		logic fanMode;
		logic timerEn;
		logic [1:0] timerSrc;
		logic protSel;
		logic [15:0] totalLimit;
		logic [15:0] sleepFreq;
		logic [15:0] wakeFreq;
		logic [15:0] sleepDelay;
		logic [15:0] wakeDelay;
		logic [15:0] timerSet;
		logic [15:0] presLimit;
	} cfg_s;
	typedef struct packed {
		logic driveRun;
		logic dormant;
		logic fanOn;
		logic timerReached;
		logic presentRunReached;
		logic totalRunReached;
	} flags_s;
	typedef struct packed {
		run_e run;
		logic [31:0] tickCnt;
		logic [5:0] minSub;
		logic [15:0] hourSub;
		logic [15:0] delayCnt;
		logic [15:0] elapsed;
		logic [15:0] hours;
		logic armed;
		logic fan;
		logic timerHit;
		logic presHit;
		logic totHit;
		cfg_s cfg;
		logic [4:0] irqStat;
		logic [4:0] irqMask;
		logic irqLine;
		logic awHeld;
		logic [7:0] awAddr;
		logic wHeld;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} state_s;
endpackage

// ==== drive_run_supervisor.sv ====
// drive run supervisor: run limits, fan, dormancy, timing, start protection
// How it works
// RULE1 - total time reached: action 0 keeps running, action 1 stops the drive
// RULE2 - fan mode 0: fan on while running, else only above 40 C; the code holds the fan's state at exactly 40 C
// RULE3 - fan mode 1: fan runs continuously from power-on; here fan mode resets to 0, fan runs from the cycle after mode 1 is set
// RULE4 - running at or below dormant frequency: dormant and stop after delay
// RULE5 - dormant, run command on, at or above wakeup frequency: restart after delay
// RULE6 - both frequencies zero disables dormant and wakeup
// RULE7 - dormant freq clamped to wakeup; wakeup between dormant and maximum
// RULE8 - software should set wakeup frequency at or above dormant frequency
// RULE9 - timing enabled: time each start, stop and flag on expiry
// RULE10 - timing restarts from zero each start; remaining time readable
// RULE11 - duration from fixed setting or analog one to three, full scale equals setting
// RULE12 - duration counted in 0.1 minute steps up to the setting
// RULE13 - present run time reaching its threshold raises its output
// RULE14 - protection 0: ignore run already on at power-on until re-asserted
// RULE15 - run held across fault reset is ignored until released once
// RULE16 - protection 1: act on run already asserted at power-on or fault reset
// RULE17 - total running hours accumulate; output raised at threshold
// RULE18 - delays and durations counted from prescaled 0.1 second tick
`timescale 1ns/1ps
`include "drive_run_supervisor_params.svh"
module drive_run_supervisor
	import drive_run_supervisor_pkg::*;
#(
	parameter int TICK_CYCLES = `TICK_CYCLES,
	parameter int HOUR_DSEC = `DSEC_PER_HOUR
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic runCmd,
	input wire logic faultReset,
	input wire logic [15:0] setFreq,
	input wire logic [15:0] maxFreq,
	input wire logic signed [7:0] heatsinkTemp,
	input wire logic [10:0] analogInputOne,
	input wire logic [10:0] analogInputTwo,
	input wire logic [10:0] analogInputThree,
	output flags_s flags,
	output logic irq,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// refuse counts that the prescaler and hour counter cannot hold
	if (TICK_CYCLES < 1 || HOUR_DSEC < 2 || HOUR_DSEC > 65535) begin : g_badCount
		$error("drive_run_supervisor: unsupported tick or hour count");
	end

	state_s s_reg;
	state_s s_next;
	logic tick, minTick, hourTick, runEff, totReached, limitStop;
	logic sleepOn, timerDone, startUp;
	logic [15:0] sleepEff, wakeEff, duration, remaining;
	logic [10:0] aiSel;
	logic [4:0] events;

	// word-aligned offsets inside the map are valid
	function automatic logic mapped(input logic [7:0] a);
		return a[1:0] == 2'b00 && a <= `OFF_IRQ_MASK;
	endfunction

	// byte lanes replace only the strobed bytes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// analog full scale (saturated) maps to the fixed setting
	function automatic logic [15:0] scaleDur(input logic [15:0] setv, input logic [10:0] ai);
		logic [10:0] a;
		logic [26:0] p;
		a = (ai > 11'(`AI_FULL)) ? 11'(`AI_FULL) : ai;
		p = setv * a;
		return p[`AI_SHIFT +: 16];
	endfunction

	// RULE18 prescaled tick
	assign tick = s_reg.tickCnt == 32'(TICK_CYCLES - 1);
	assign minTick = tick && s_reg.minSub == 6'(`DSEC_PER_DMIN - 1);
	assign hourTick = tick && s_reg.hourSub == 16'(HOUR_DSEC - 1);
	// RULE14 RULE16 protection gate
	assign runEff = runCmd && !(s_reg.armed && !s_reg.cfg.protSel);
	// RULE17 total hour threshold
	assign totReached = s_reg.cfg.totalLimit != 16'h0000 && s_reg.hours >= s_reg.cfg.totalLimit;
	// RULE1 stop on limit
	assign limitStop = totReached && s_reg.cfg.action;
	// RULE6 enable of dormancy
	assign sleepOn = s_reg.cfg.sleepFreq != 16'h0000 || s_reg.cfg.wakeFreq != 16'h0000;
	// RULE7 clamped frequencies
	assign sleepEff = (s_reg.cfg.sleepFreq > s_reg.cfg.wakeFreq) ? s_reg.cfg.wakeFreq
		: s_reg.cfg.sleepFreq;
	assign wakeEff = (s_reg.cfg.wakeFreq < sleepEff) ? sleepEff
		: (s_reg.cfg.wakeFreq > maxFreq) ? maxFreq : s_reg.cfg.wakeFreq;

	// RULE11 duration source select
	always_comb begin
		case (s_reg.cfg.timerSrc)
			2'h1: aiSel = analogInputOne;
			2'h2: aiSel = analogInputTwo;
			2'h3: aiSel = analogInputThree;
			default: aiSel = 11'(`AI_FULL);
		endcase
	end
	assign duration = scaleDur(s_reg.cfg.timerSet, aiSel);
	// RULE9 expiry
	assign timerDone = s_reg.cfg.timerEn && s_reg.elapsed >= duration;
	// RULE10 remaining time view
	assign remaining = (s_reg.elapsed >= duration) ? 16'h0000 : duration - s_reg.elapsed;

	// whole next state: counters, run machine, flags, bus
	always_comb begin
		s_next = s_reg;
		startUp = 1'b0;
		events = '0;
		s_next.tickCnt = tick ? 32'h0000_0000 : s_reg.tickCnt + 32'h0000_0001;
		// RULE12 run time in 0.1 minute steps
		if (s_reg.run == RUN_ST && tick) begin
			s_next.minSub = minTick ? 6'h00 : s_reg.minSub + 6'h01;
			s_next.hourSub = hourTick ? 16'h0000 : s_reg.hourSub + 16'h0001;
			if (minTick && s_reg.elapsed != 16'hffff) begin
				s_next.elapsed = s_reg.elapsed + 16'h0001;
			end
			// RULE17 hour accumulation
			if (hourTick && s_reg.hours != 16'hffff) begin
				s_next.hours = s_reg.hours + 16'h0001;
			end
		end
		// RULE15 fault reset re-arms; release disarms
		if (faultReset) begin
			s_next.armed = 1'b1;
		end else if (!runCmd) begin
			s_next.armed = 1'b0;
		end
		case (s_reg.run)
			IDLE_ST: begin
				if (runEff && !limitStop) begin
					startUp = 1'b1;
				end
			end
			RUN_ST: begin
				if (!runEff) begin
					s_next.run = IDLE_ST;
				end else if (limitStop) begin
					s_next.run = HALT_ST;
				end else if (timerDone) begin
					s_next.run = HALT_ST;
					s_next.timerHit = 1'b1;
				// RULE4 dormant entry
				end else if (sleepOn && setFreq <= sleepEff) begin
					if (s_reg.delayCnt >= s_reg.cfg.sleepDelay) begin
						s_next.run = DORM_ST;
						s_next.delayCnt = 16'h0000;
						events[`IRQ_DORMANT] = 1'b1;
					end else if (tick) begin
						s_next.delayCnt = s_reg.delayCnt + 16'h0001;
					end
				end else begin
					s_next.delayCnt = 16'h0000;
				end
			end
			DORM_ST: begin
				if (!runEff) begin
					s_next.run = IDLE_ST;
				// RULE5 wakeup
				end else if (setFreq >= wakeEff) begin
					if (s_reg.delayCnt >= s_reg.cfg.wakeDelay) begin
						startUp = 1'b1;
						events[`IRQ_WAKE] = 1'b1;
					end else if (tick) begin
						s_next.delayCnt = s_reg.delayCnt + 16'h0001;
					end
				end else begin
					s_next.delayCnt = 16'h0000;
				end
			end
			HALT_ST: begin
				if (!runEff) begin
					s_next.run = IDLE_ST;
				end
			end
			default: s_next.run = IDLE_ST;
		endcase
		// RULE10 timing restarts at every start
		if (startUp) begin
			s_next.run = RUN_ST;
			s_next.elapsed = 16'h0000;
			s_next.minSub = 6'h00;
			s_next.delayCnt = 16'h0000;
			s_next.timerHit = 1'b0;
			s_next.presHit = 1'b0;
		end
		// RULE13 present run threshold
		if (s_reg.run == RUN_ST && s_reg.cfg.presLimit != 16'h0000
			&& s_reg.elapsed >= s_reg.cfg.presLimit) begin
			s_next.presHit = 1'b1;
		end
		s_next.totHit = totReached;
		// RULE2 RULE3 fan; at exactly 40 C the fan keeps its state
		if (s_reg.cfg.fanMode || s_reg.run == RUN_ST || heatsinkTemp > 8'sd40) begin
			s_next.fan = 1'b1;
		end else if (heatsinkTemp < 8'sd40) begin
			s_next.fan = 1'b0;
		end
		events[`IRQ_TIMER] = s_next.timerHit && !s_reg.timerHit;
		events[`IRQ_PRES] = s_next.presHit && !s_reg.presHit;
		events[`IRQ_TOTAL] = s_next.totHit && !s_reg.totHit;
		// axi write: address and data captured in either order
		if (s_axi_awvalid && s_axi_awready) begin
			s_next.awHeld = 1'b1;
			s_next.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_next.wHeld = 1'b1;
			s_next.wData = s_axi_wdata;
			s_next.wStrb = s_axi_wstrb;
		end
		if (s_reg.bvalid && s_axi_bready) begin
			s_next.bvalid = 1'b0;
		end
		if (s_reg.awHeld && s_reg.wHeld && !s_reg.bvalid) begin
			s_next.awHeld = 1'b0;
			s_next.wHeld = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = mapped(s_reg.awAddr) ? `RESP_OKAY : `RESP_SLVERR;
			case (s_reg.awAddr)
				`OFF_CTRL: begin
					s_next.cfg.action = s_reg.wStrb[0] ? s_reg.wData[`CTRL_ACTION] : s_reg.cfg.action;
					s_next.cfg.fanMode = s_reg.wStrb[0] ? s_reg.wData[`CTRL_FAN] : s_reg.cfg.fanMode;
					s_next.cfg.timerEn = s_reg.wStrb[0] ? s_reg.wData[`CTRL_TIMER_EN]
						: s_reg.cfg.timerEn;
					s_next.cfg.timerSrc = s_reg.wStrb[0] ? s_reg.wData[`CTRL_SRC_HI:`CTRL_SRC_LO]
						: s_reg.cfg.timerSrc;
					s_next.cfg.protSel = s_reg.wStrb[0] ? s_reg.wData[`CTRL_PROT] : s_reg.cfg.protSel;
				end
				`OFF_TOTAL_LIMIT: s_next.cfg.totalLimit =
					16'(merge({16'h0000, s_reg.cfg.totalLimit}, s_reg.wData, s_reg.wStrb));
				`OFF_FREQ: {s_next.cfg.wakeFreq, s_next.cfg.sleepFreq} =
					merge({s_reg.cfg.wakeFreq, s_reg.cfg.sleepFreq}, s_reg.wData, s_reg.wStrb);
				`OFF_DELAY: {s_next.cfg.wakeDelay, s_next.cfg.sleepDelay} =
					merge({s_reg.cfg.wakeDelay, s_reg.cfg.sleepDelay}, s_reg.wData, s_reg.wStrb);
				`OFF_TIMER_SET: s_next.cfg.timerSet =
					16'(merge({16'h0000, s_reg.cfg.timerSet}, s_reg.wData, s_reg.wStrb));
				`OFF_PRES_LIMIT: s_next.cfg.presLimit =
					16'(merge({16'h0000, s_reg.cfg.presLimit}, s_reg.wData, s_reg.wStrb));
				`OFF_IRQ_MASK: s_next.irqMask = s_reg.wStrb[0] ? s_reg.wData[4:0] : s_reg.irqMask;
				default: s_next.bresp = s_next.bresp;
			endcase
		end
		// axi read; interrupt status read clears, a new event in that cycle survives
		if (s_reg.rvalid && s_axi_rready) begin
			s_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			s_next.rvalid = 1'b1;
			s_next.rresp = mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
			case (s_axi_araddr)
				`OFF_CTRL: s_next.rdata = {26'h0, s_reg.cfg.protSel, s_reg.cfg.timerSrc,
					s_reg.cfg.timerEn, s_reg.cfg.fanMode, s_reg.cfg.action};
				`OFF_TOTAL_LIMIT: s_next.rdata = {16'h0000, s_reg.cfg.totalLimit};
				`OFF_FREQ: s_next.rdata = {s_reg.cfg.wakeFreq, s_reg.cfg.sleepFreq};
				`OFF_DELAY: s_next.rdata = {s_reg.cfg.wakeDelay, s_reg.cfg.sleepDelay};
				`OFF_TIMER_SET: s_next.rdata = {16'h0000, s_reg.cfg.timerSet};
				`OFF_PRES_LIMIT: s_next.rdata = {16'h0000, s_reg.cfg.presLimit};
				`OFF_STATUS: s_next.rdata = {24'h0, s_reg.armed, s_reg.run, s_reg.fan,
					s_reg.timerHit, s_reg.presHit, s_reg.totHit, 1'b0};
				`OFF_REMAIN: s_next.rdata = {16'h0000, remaining};
				`OFF_HOURS: s_next.rdata = {16'h0000, s_reg.hours};
				`OFF_IRQ_STAT: begin
					s_next.rdata = {27'h0, s_reg.irqStat};
					s_next.irqStat = 5'h00;
				end
				`OFF_IRQ_MASK: s_next.rdata = {27'h0, s_reg.irqMask};
				default: s_next.rdata = `RESET_ZERO;
			endcase
		end
		s_next.irqStat = s_next.irqStat | events;
		s_next.irqLine = |(s_next.irqStat & s_next.irqMask);
	end

	// state register; power-on arms start protection
	always_ff @(posedge mclk) begin
		if (srst) begin
			s_reg <= '0;
			s_reg.armed <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// handshakes from state, data from flops
	assign s_axi_awready = !s_reg.awHeld && !s_reg.bvalid;
	assign s_axi_wready = !s_reg.wHeld && !s_reg.bvalid;
	assign s_axi_bvalid = s_reg.bvalid;
	assign s_axi_bresp = s_reg.bresp;
	assign s_axi_arready = !s_reg.rvalid;
	assign s_axi_rvalid = s_reg.rvalid;
	assign s_axi_rdata = s_reg.rdata;
	assign s_axi_rresp = s_reg.rresp;
	assign irq = s_reg.irqLine;
	assign flags = '{driveRun: s_reg.run == RUN_ST, dormant: s_reg.run == DORM_ST,
		fanOn: s_reg.fan, timerReached: s_reg.timerHit, presentRunReached: s_reg.presHit,
		totalRunReached: s_reg.totHit};

	// checks on the run machine and outputs
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	sequence s_sleepDue;
		s_reg.run == RUN_ST && runEff && !limitStop && !timerDone && sleepOn
			&& setFreq <= sleepEff && s_reg.delayCnt >= s_reg.cfg.sleepDelay;
	endsequence
	sequence s_wakeDue;
		s_reg.run == DORM_ST && runEff && setFreq >= wakeEff
			&& s_reg.delayCnt >= s_reg.cfg.wakeDelay;
	endsequence
	property p_limitStop;
		s_reg.run == RUN_ST && runEff && limitStop |=> flags.driveRun == 1'b0 ##1 !flags.driveRun;
	endproperty
	a_limitStop: assert property (p_limitStop) else $error("limit did not stop"); // RULE1
	property p_fanRun;
		!s_reg.cfg.fanMode && s_reg.run == RUN_ST |=> flags.fanOn;
	endproperty
	a_fanRun: assert property (p_fanRun) else $error("fan off while running"); // RULE2
	property p_fanCool;
		!s_reg.cfg.fanMode && s_reg.run != RUN_ST && heatsinkTemp < 8'sd40 |=> !flags.fanOn;
	endproperty
	a_fanCool: assert property (p_fanCool) else $error("fan on while cool and stopped"); // RULE2
	property p_fanAlways;
		s_reg.cfg.fanMode |=> flags.fanOn;
	endproperty
	a_fanAlways: assert property (p_fanAlways) else $error("fan off in mode one"); // RULE3
	property p_sleep;
		s_sleepDue |=> flags.dormant && !flags.driveRun;
	endproperty
	a_sleep: assert property (p_sleep) else $error("dormant entry missed"); // RULE4
	property p_wake;
		s_wakeDue |=> flags.driveRun && s_reg.elapsed == 16'h0000;
	endproperty
	a_wake: assert property (p_wake) else $error("wakeup missed"); // RULE5
	property p_noSleep;
		s_reg.run == RUN_ST && !sleepOn |=> !flags.dormant;
	endproperty
	a_noSleep: assert property (p_noSleep) else $error("dormant while disabled"); // RULE6
	property p_clamp;
		sleepEff <= s_reg.cfg.wakeFreq && wakeEff <= maxFreq
			&& (maxFreq < sleepEff || wakeEff >= sleepEff);
	endproperty
	a_clamp: assert property (p_clamp) else $error("frequency clamp broken"); // RULE7
	property p_timer;
		s_reg.run == RUN_ST && runEff && !limitStop && timerDone
			|=> flags.timerReached && !flags.driveRun;
	endproperty
	a_timer: assert property (p_timer) else $error("timer expiry missed"); // RULE9
	property p_protect;
		s_reg.run == IDLE_ST && s_reg.armed && !s_reg.cfg.protSel |=> !flags.driveRun;
	endproperty
	a_protect: assert property (p_protect) else $error("protected start taken"); // RULE14
	property p_rearm;
		faultReset |=> s_reg.armed;
	endproperty
	a_rearm: assert property (p_rearm) else $error("fault reset did not arm"); // RULE15
	property p_presRun;
		s_reg.run == RUN_ST && s_reg.cfg.presLimit != 16'h0000
			&& s_reg.elapsed >= s_reg.cfg.presLimit |=> flags.presentRunReached;
	endproperty
	a_presRun: assert property (p_presRun) else $error("present run flag missed"); // RULE13
	property p_irq;
		irq == |(s_reg.irqStat & s_reg.irqMask);
	endproperty
	a_irq: assert property (p_irq) else $error("irq line mismatch");
endmodule // drive_run_supervisor

// ==== drive_terminals_model.sv ====
// far-side model: run command and fault reset terminals of the drive
`timescale 1ns/1ps
module drive_terminals_model (
	input wire logic mclk,
	input wire logic wantRun,
	input wire logic wantFault,
	output logic runCmd,
	output logic faultReset
);
	// a contact already closed at power-on, so protection has something to ignore
	initial begin
		runCmd = 1'b1;
		faultReset = 1'b0;
	end
	// terminals move just after an edge, one cycle behind the request
	always @(posedge mclk) begin
		runCmd <= wantRun;
		faultReset <= wantFault;
	end
endmodule // drive_terminals_model

// ==== drive_run_supervisor_tb.sv ====
// self-checking bench of the drive run supervisor
`timescale 1ns/1ps
`include "drive_run_supervisor_params.svh"
module drive_run_supervisor_tb;
	import drive_run_supervisor_pkg::*;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic wantRun = 1'b1;
	logic wantFault = 1'b0;
	logic runCmd, faultReset, irq;
	logic [15:0] setFreq = 16'h1388;
	logic [15:0] maxFreq = 16'h1388;
	logic signed [7:0] heatsinkTemp = 8'sh19;
	logic [10:0] aiVal [3] = '{11'h400, 11'h400, 11'h400};
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rsp;
	logic [31:0] rdata, rd;
	flags_s flags;
	logic [5:0] fl;
	int errCount = 0;
	int checks = 0;
	int s, k;
	assign fl = flags;
	// 250 MHz
	always #2 mclk = ~mclk;
	drive_terminals_model u_drive_terminals_model (.mclk(mclk), .wantRun(wantRun),
		.wantFault(wantFault), .runCmd(runCmd), .faultReset(faultReset));
	// small prescale so 0.1 s is 4 cycles and one hour 12 cycles
	drive_run_supervisor #(.TICK_CYCLES(4), .HOUR_DSEC(3)) u_drive_run_supervisor (
		.mclk(mclk), .srst(srst), .runCmd(runCmd), .faultReset(faultReset),
		.setFreq(setFreq), .maxFreq(maxFreq), .heatsinkTemp(heatsinkTemp),
		.analogInputOne(aiVal[0]), .analogInputTwo(aiVal[1]), .analogInputThree(aiVal[2]),
		.flags(flags), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	// verdict and counts, also reached from any timeout
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, errCount);
		if (errCount == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			errCount++;
			$display("[FAIL] %0t %s got %h", $time, m, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic run(input logic v);
		@(posedge mclk);
		wantRun <= v;
	endtask
	task automatic pulse_fault();
		@(posedge mclk);
		wantFault <= 1'b1;
		cyc(2);
		wantFault <= 1'b0;
	endtask
	// bounded wait for one flag; the flag is sampled mid-cycle where it is settled
	task automatic wait_bit(input int i, input logic v, input int n, input string m);
		for (k = 0; k < n && fl[i] !== v; k++) begin
			@(negedge mclk);
		end
		chk(fl[i], v, m);
		if (fl[i] !== v) begin
			end_of_test();
		end
	endtask
	task automatic hold_bit(input int i, input logic v, input int n, input string m);
		logic ok;
		ok = 1'b1;
		repeat (n) begin
			@(negedge mclk);
			ok &= (fl[i] === v);
		end
		chk(ok, 1'b1, m);
	endtask
	// one register access; each channel released at the edge that takes it
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		logic pa, pw, pb, ta, tw, tb;
		pa = 1'b1;
		pw = w;
		pb = 1'b1;
		@(posedge mclk);
		if (w) begin
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
		end else begin
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
		end
		for (n = 0; n < 40 && (pa || pw || pb); n++) begin
			@(negedge mclk);
			ta = pa && (w ? awready : arready);
			tw = pw && wready;
			tb = pb && (w ? bvalid : rvalid);
			rsp = w ? bresp : rresp;
			rd = rdata;
			@(posedge mclk);
			if (ta) begin
				pa = 1'b0;
				awvalid <= 1'b0;
				arvalid <= 1'b0;
			end
			if (tw) begin
				pw = 1'b0;
				wvalid <= 1'b0;
			end
			if (tb) begin
				pb = 1'b0;
				bready <= 1'b0;
				rready <= 1'b0;
			end
		end
		if (pa || pw || pb) begin
			chk(1'b0, 1'b1, "bus timeout");
			end_of_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
		chk(rsp, `RESP_OKAY, "write response");
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r,
		input string m);
		bus(1'b0, a, 32'h0000_0000);
		chk(rd, e, m);
		chk(rsp, r, m);
	endtask
	// main sequence; run command stays high through reset
	initial begin
		cyc(20);
		srst <= 1'b0;
		rdchk(`OFF_CTRL, `RESET_ZERO, `RESP_OKAY, "ctrl reset");
		rdchk(`OFF_IRQ_MASK, `RESET_ZERO, `RESP_OKAY, "mask reset");
		rdchk(8'h30, `RESET_ZERO, `RESP_SLVERR, "unmapped read");
		$display("test registers done");
		hold_bit(5, 1'b0, 40, "power-on run obeyed");
		run(1'b0);
		cyc(3);
		run(1'b1);
		wait_bit(5, 1'b1, 10, "re-asserted run ignored");
		wait_bit(3, 1'b1, 5, "fan off while running");
		pulse_fault();
		wait_bit(5, 1'b0, 5, "fault reset did not stop run");
		hold_bit(5, 1'b0, 30, "run held over fault reset obeyed");
		run(1'b0);
		cyc(3);
		run(1'b1);
		wait_bit(5, 1'b1, 10, "released run ignored");
		wr(`OFF_CTRL, 32'h0000_0020);
		pulse_fault();
		hold_bit(5, 1'b1, 30, "unprotected run dropped");
		$display("test start protection done");
		@(posedge mclk);
		setFreq <= 16'h0000;
		hold_bit(4, 1'b0, 60, "dormant with zero frequencies");
		@(posedge mclk);
		setFreq <= 16'h1388;
		wr(`OFF_DELAY, {16'h0003, 16'h0005});
		wr(`OFF_IRQ_MASK, 32'h0000_0008);
		// wakeup kept above dormant, as the configuring side must
		wr(`OFF_FREQ, {16'h07d0, 16'h03e8});
		bus(1'b0, `OFF_IRQ_STAT, 32'h0000_0000);
		setFreq <= 16'h01f4;
		hold_bit(4, 1'b0, 12, "dormant before delay");
		wait_bit(4, 1'b1, 15, "dormant after delay");
		chk(fl[5], 1'b0, "drive not stopped in dormancy");
		cyc(3);
		chk(irq, 1'b1, "dormant interrupt");
		rdchk(`OFF_IRQ_STAT, 32'h0000_0008, `RESP_OKAY, "dormant event");
		cyc(3);
		chk(irq, 1'b0, "interrupt after clear");
		setFreq <= 16'h09c4;
		hold_bit(5, 1'b0, 6, "wakeup before delay");
		wait_bit(5, 1'b1, 12, "wakeup after delay");
		rdchk(`OFF_IRQ_STAT, 32'h0000_0010, `RESP_OKAY, "wakeup event");
		wr(`OFF_FREQ, {16'h07d0, 16'h0bb8});
		hold_bit(4, 1'b0, 60, "dormant above clamped frequency");
		wr(`OFF_FREQ, 32'h0000_0000);
		$display("test dormancy done");
		run(1'b0);
		wait_bit(5, 1'b0, 10, "stop");
		wr(`OFF_TIMER_SET, 32'h0000_0002);
		wr(`OFF_CTRL, 32'h0000_0024);
		run(1'b1);
		wait_bit(5, 1'b1, 10, "timed start");
		rdchk(`OFF_REMAIN, 32'h0000_0002, `RESP_OKAY, "remaining at start");
		hold_bit(2, 1'b0, 440, "timer early");
		wait_bit(2, 1'b1, 60, "timer expiry");
		wait_bit(5, 1'b0, 3, "drive after expiry");
		// each analog source at half scale halves the fixed duration
		for (s = 1; s < 4; s++) begin
			run(1'b0);
			for (int j = 0; j < 3; j++) begin
				aiVal[j] <= (j == s - 1) ? 11'h200 : 11'h400;
			end
			wr(`OFF_CTRL, 32'h0000_0024 | (s << 3));
			run(1'b1);
			wait_bit(5, 1'b1, 10, "timed start");
			rdchk(`OFF_REMAIN, 32'h0000_0001, `RESP_OKAY, "analog remaining");
			hold_bit(2, 1'b0, 200, "analog timer early");
			wait_bit(2, 1'b1, 60, "analog timer expiry");
		end
		$display("test timing done");
		run(1'b0);
		wr(`OFF_CTRL, 32'h0000_0020);
		wr(`OFF_PRES_LIMIT, 32'h0000_0001);
		run(1'b1);
		hold_bit(1, 1'b0, 200, "present run early");
		wait_bit(1, 1'b1, 60, "present run reached");
		chk(fl[5], 1'b1, "drive after present run");
		run(1'b0);
		bus(1'b0, `OFF_HOURS, 32'h0000_0000);
		wr(`OFF_TOTAL_LIMIT, rd + 32'h0000_0002);
		run(1'b1);
		hold_bit(0, 1'b0, 10, "total hours early");
		wait_bit(0, 1'b1, 30, "total hours reached");
		chk(fl[5], 1'b1, "action 0 stopped drive");
		wr(`OFF_CTRL, 32'h0000_0021);
		wait_bit(5, 1'b0, 10, "action 1 kept running");
		$display("test run time done");
		run(1'b0);
		wait_bit(3, 1'b0, 10, "fan on while stopped and cool");
		@(posedge mclk);
		heatsinkTemp <= 8'sh2d;
		wait_bit(3, 1'b1, 5, "fan off while hot");
		@(posedge mclk);
		heatsinkTemp <= 8'sh19;
		wait_bit(3, 1'b0, 5, "fan on after cooling");
		wr(`OFF_CTRL, 32'h0000_0022);
		wait_bit(3, 1'b1, 5, "fan mode 1 off");
		$display("test fan done");
		end_of_test();
	end
endmodule // drive_run_supervisor_tb
